// ===== rrsl_core.sv
// execution datapath: rotate right through carry and subtract w from literal
// Functional notes
// - rotate file register right through carry
// - destination bit picks w or file
// - literal minus w by two's complement
// - 8-bit literal operand, result into w
`include "rrsl_defs.svh"
module rrsl_core #(
  parameter int DATA_W = `RRSL_DATA_W
) (
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire rrsl_pkg::rrsl_req_t    req,
  input  wire logic                   req_valid,
  output logic [7:0]                  w_reg,
  output rrsl_pkg::rrsl_flags_t       flags_reg,
  output logic [7:0]                  file_wr_data_reg,
  output logic                        file_wr_en_reg
);
  import rrsl_pkg::*;

  if (DATA_W != 8) begin : g_chk
    $error("rrsl_core supports only an 8-bit datapath");
  end

  // decode; code 11 or req_valid low falls through as idle
  wire logic       is_rot     = req_valid && (req.op == rotate_right_through_carry_op);
  wire logic       is_subl    = req_valid && (req.op == subtract_w_from_literal_op);
  wire logic       rot_to_f   = is_rot && (req.dest_f == `RRSL_DEST_F);
  wire logic       rot_to_w   = is_rot && (req.dest_f == `RRSL_DEST_W);

  // rotate: old carry enters bit 7, bit 0 leaves into carry
  wire logic [7:0] rot_res;
  for (genvar b = 0; b < 7; b++) begin : g_rot
    assign rot_res[b] = req.file_val[b+1];
  end
  assign rot_res[7] = flags_reg.carry;
  wire logic       rot_carry  = req.file_val[0];

  // lit + ~w + 1; the ninth bit is the no-borrow carry
  wire logic [8:0] sub_sum    = {1'b0, req.lit} + {1'b0, ~w_reg} + 9'h001;
  wire logic [4:0] nib_sum    = {1'b0, req.lit[3:0]} + {1'b0, ~w_reg[3:0]} + 5'h01;
  wire logic [7:0] sub_res    = sub_sum[7:0];

  logic [7:0]  w_next;
  rrsl_flags_t flags_next;
  logic [7:0]  fwd_next;
  logic        fwe_next;

  always_comb begin
    w_next     = w_reg;
    flags_next = flags_reg;
    fwd_next   = file_wr_data_reg;
    fwe_next   = 1'b0;
    if (is_rot) begin
      flags_next.carry = rot_carry;
      if (rot_to_f) begin
        fwd_next = rot_res;
        fwe_next = 1'b1;
      end else begin
        w_next = rot_res;
      end
    end else if (is_subl) begin
      w_next                      = sub_res;
      flags_next.carry            = sub_sum[8];
      flags_next.digit_carry_flag = nib_sum[4];
      flags_next.zero             = (sub_res == 8'h00);
    end
  end

  // one register per block; reset is synchronous like the rest of the core
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      w_reg <= `RRSL_W_RST;
    end else begin
      w_reg <= w_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flags_reg <= '{carry: `RRSL_CARRY_RST, digit_carry_flag: 1'h0, zero: 1'h0};
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      file_wr_data_reg <= 8'h00;
    end else begin
      file_wr_data_reg <= fwd_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      file_wr_en_reg <= 1'h0;
    end else begin
      file_wr_en_reg <= fwe_next;
    end
  end

  // assertions; chained checks prove each op sees the previous w and carry
  sequence s_rot;
    is_rot;
  endsequence

  sequence s_rot_f;
    rot_to_f;
  endsequence

  sequence s_rot_w;
    rot_to_w;
  endsequence

  sequence s_sub;
    is_subl;
  endsequence

  sequence s_idle;
    !is_rot && !is_subl;
  endsequence

  sequence s_bad_code;
    req_valid && (req.op == 2'h3);
  endsequence

  a_rotate_result: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_rot_f |=> file_wr_en_reg &&
      file_wr_data_reg == {$past(flags_reg.carry), $past(req.file_val[7:1])} &&
      flags_reg.carry == $past(req.file_val[0]))
    else $error("rotate result or carry wrong");

  a_rotate_to_w: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_rot_w |=> !file_wr_en_reg &&
      w_reg == {$past(flags_reg.carry), $past(req.file_val[7:1])})
    else $error("rotate to w wrong");

  a_file_keeps_w: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_rot_f |=> w_reg == $past(w_reg))
    else $error("w changed on file destination");

  a_sub_value: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_subl |=> w_reg == 8'($past(req.lit) - $past(w_reg)))
    else $error("literal minus w wrong");

  a_sub_no_file: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_subl |=> !file_wr_en_reg)
    else $error("subtract wrote file");

  a_sub_carry: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_subl |=> flags_reg.carry == ($past(w_reg) <= $past(req.lit)))
    else $error("carry flag wrong");

  a_sub_dcarry: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_subl |=> flags_reg.digit_carry_flag == ($past(w_reg[3:0]) <= $past(req.lit[3:0])))
    else $error("digit carry flag wrong");

  a_sub_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_subl |=> flags_reg.zero == ($past(w_reg) == $past(req.lit)))
    else $error("zero flag wrong");

  a_idle_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_idle |=> !file_wr_en_reg && $stable(w_reg) && $stable(flags_reg))
    else $error("state changed while idle");

  a_bad_code_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_bad_code |=> !file_wr_en_reg && $stable(w_reg) && $stable(flags_reg) &&
      $stable(file_wr_data_reg))
    else $error("unused op code changed state");

  a_rotate_keeps_dz: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_rot |=> flags_reg.digit_carry_flag == $past(flags_reg.digit_carry_flag) &&
      flags_reg.zero == $past(flags_reg.zero))
    else $error("rotate touched digit carry or zero");

  a_rot_w_keeps_file: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_rot_w |=> $stable(file_wr_data_reg))
    else $error("rotate to w moved file data");

  a_file_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
    file_wr_en_reg |-> $past(rot_to_f))
    else $error("file write without a rotate to file");

  a_file_data_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !rot_to_f |=> $stable(file_wr_data_reg))
    else $error("file data moved without a write");

  a_sub_keeps_file: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_sub |=> $stable(file_wr_data_reg))
    else $error("subtract moved file data");

  a_w_source: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !$stable(w_reg) |-> $past(rot_to_w || is_subl))
    else $error("w changed without an op aimed at it");

  a_flags_source: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !$stable(flags_reg) |-> $past(is_rot || is_subl))
    else $error("flags changed without an op");

  a_borrow_case: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_subl && (w_reg > req.lit) |=> !flags_reg.carry && !flags_reg.zero)
    else $error("borrow case left carry or zero set");

  a_dcarry_equal: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_subl && (req.lit[3:0] == w_reg[3:0]) |=> flags_reg.digit_carry_flag)
    else $error("equal low nibbles must not borrow");

  // multi-step: each op must see the w and carry left by the one before
  a_sub_chain: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_sub ##1 s_sub |=>
      w_reg == 8'($past(req.lit) - $past(req.lit, 2) + $past(w_reg, 2)))
    else $error("back-to-back subtract lost w");

  a_rot_chain: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_rot ##1 s_rot |=>
      (file_wr_en_reg ? file_wr_data_reg[7] : w_reg[7]) == $past(req.file_val[0], 2))
    else $error("back-to-back rotate lost carry");

  a_sub_rot_chain: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_sub ##1 s_rot |=>
      (file_wr_en_reg ? file_wr_data_reg[7] : w_reg[7]) ==
      ($past(w_reg, 2) <= $past(req.lit, 2)))
    else $error("rotate ignored carry from subtract");

  a_rot_sub_chain: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_rot_w ##1 s_sub |=>
      w_reg == 8'($past(req.lit) - {$past(flags_reg.carry, 2), $past(req.file_val[7:1], 2)}))
    else $error("subtract ignored w from rotate");

  a_reset_clear: assert property (@(posedge ref_clk)
    sys_rst |=> w_reg == `RRSL_W_RST && flags_reg == 3'h0 && !file_wr_en_reg &&
      file_wr_data_reg == 8'h00)
    else $error("reset left state behind");
endmodule

// ===== rrsl_core_bench.sv
// self-checking bench for the rotate / literal-subtract datapath
module rrsl_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import rrsl_pkg::*;
  logic        ref_clk = 0;
  logic        sys_rst = 1;
  rrsl_req_t   req = '0;
  logic        req_valid = 0;
  logic [7:0]  w_reg;
  logic [7:0]  file_wr_data_reg;
  rrsl_flags_t flags_reg;
  logic        file_wr_en_reg;
  logic [19:0] exp_q[$];
  logic [7:0]  mw = 8'h00;
  logic [7:0]  mf = 8'h00;
  logic        mc = 0;
  logic        md = 0;
  logic        mz = 0;
  logic [7:0]  lits[5] = '{8'h00, 8'h05, 8'h05, 8'h04, 8'h03};
  int          miscompares = 0;
  int          n_compared = 0;
  int          seed = 20746;
  rrsl_core dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .req_valid(req_valid),
    .w_reg(w_reg), .flags_reg(flags_reg), .file_wr_data_reg(file_wr_data_reg),
    .file_wr_en_reg(file_wr_en_reg));
  initial forever #2 ref_clk = ~ref_clk;
  task automatic report_and_stop;
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // model steps at issue; note is queued once the edge has taken the op
  task automatic do_op(rrsl_op_t op, logic d, logic [7:0] k, logic [7:0] f, logic v);
    logic [7:0] r;
    logic       we;
    r = {mc, f[7:1]};
    we = 0;
    req = '{op, d, k, f};
    req_valid = v;
    if (v && op == rotate_right_through_carry_op) begin
      mc = f[0];
      we = d;
      if (d) mf = r;
      else mw = r;
    end else if (v && op == subtract_w_from_literal_op) begin
      r = k - mw;
      mc = mw <= k;
      md = mw[3:0] <= k[3:0];
      mz = r == 8'h00;
      mw = r;
    end
    @(posedge ref_clk);
    exp_q.push_back({mw, mc, md, mz, we, mf});
    #1;
  endtask
  task automatic check(logic [19:0] e);
    logic [19:0] g;
    g = {w_reg, flags_reg, file_wr_en_reg, file_wr_data_reg};
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t outputs %h expected %h", $time, g, e);
    end
  endtask
  always @(posedge ref_clk) begin
    #2;
    while (exp_q.size() > 0) check(exp_q.pop_front());
  end
  initial begin
    #1;
    repeat (12) @(posedge ref_clk);
    #1;
    sys_rst = 0;
    do_op(no_op, 0, 8'h00, 8'h00, 0);
    foreach (lits[i]) do_op(subtract_w_from_literal_op, 0, lits[i], 8'h00, 1);
    do_op(rotate_right_through_carry_op, 1, 8'h00, 8'hE6, 1);
    do_op(rotate_right_through_carry_op, 1, 8'h00, 8'h01, 1);
    do_op(rotate_right_through_carry_op, 0, 8'h00, 8'h80, 1);
    // random mix, op 11 and idle cycles included
    repeat (300) do_op(rrsl_op_t'(2'($random(seed))), 1'($random(seed)),
      8'($random(seed)), 8'($random(seed)), 3'($random(seed)) != 3'h0);
    #4;
    report_and_stop();
  end
  // whole run is about 320 cycles
  initial begin
    #5000;
    miscompares++;
    report_and_stop();
  end
endmodule

// ===== rrsl_defs.svh
// constants for the rotate / literal-subtract datapath
`ifndef RRSL_DEFS_SVH
`define RRSL_DEFS_SVH
`define RRSL_DATA_W     8
`define RRSL_W_RST      8'h00
`define RRSL_CARRY_RST  1'h0
`define RRSL_DEST_W     1'h0
`define RRSL_DEST_F     1'h1
`define RRSL_NIB_W      4
`endif

// ===== rrsl_pkg.sv
// types for the rotate / literal-subtract datapath
package rrsl_pkg;
  typedef enum logic [1:0] {
    no_op                         = 2'b00,
    rotate_right_through_carry_op = 2'b01,
    subtract_w_from_literal_op    = 2'b10
  } rrsl_op_t;

  typedef struct packed {
    rrsl_op_t   op;
    logic       dest_f;
    logic [7:0] lit;
    logic [7:0] file_val;
  } rrsl_req_t;

  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } rrsl_flags_t;
endpackage
